// ===== seq_pkg.sv
// constants shared by the conversion sequencer: timing, register map, fields
// assumes a 125 MHz sys_clk acting as the converter master clock
package seq_pkg;
   // ----------------------------------------
   // phase lengths in master clock cycles
   // ----------------------------------------
   localparam int SETTLE1_CYC = 44;
   localparam int SETTLE2_CYC = 42;
   localparam int SCALE_CYC = 163;
   localparam int SAMPLE_UNIT_RST = 64;
   // ----------------------------------------
   // register byte addresses and address group codes
   // ----------------------------------------
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_IO = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_ADC_ZS = 8'h0c;
   localparam logic [7:0] ADDR_ADC_FS = 8'h10;
   localparam logic [2:0] REG_GLOBAL = 3'h0;
   localparam logic [2:0] REG_CFG = 3'h1;
   localparam logic [2:0] REG_DATA = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam logic [2:0] REG_CH_ZS = 3'h4;
   localparam logic [2:0] REG_CH_FS = 3'h5;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int MODE_OP_LSB = 0;
   localparam int MODE_CH_LSB = 3;
   localparam int MODE_CLAMP_BIT = 6;
   localparam int IO_SYNC_BIT = 0;
   localparam int CFG_FW_LSB = 0;
   localparam int CFG_CHOP_BIT = 8;
   localparam int CFG_EN_BIT = 9;
   localparam int CFG_BIP_BIT = 10;
   localparam int CHZS_SIGN_BIT = 22;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [23:0] ADC_ZS_RST = 24'h000000;
   localparam logic [23:0] ADC_FS_RST = 24'h200000;
   localparam logic [23:0] CH_ZS_RST = 24'h000000;
   localparam logic [23:0] CH_FS_RST = 24'h200000;
   localparam logic [10:0] CFG_RST = 11'h208;
   // ----------------------------------------
   // scaling constants
   // ----------------------------------------
   localparam int UNI_SHIFT = 21;
   localparam int BIP_SHIFT = 22;
   localparam logic signed [63:0] MID_CODE = 64'sh800000;
   localparam logic signed [63:0] FULL_CODE = 64'shffffff;
   localparam logic signed [63:0] UNITY_GAIN = 64'sh200000;
   // ----------------------------------------
   // operation codes and states
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_IDLE = 3'b000, OP_SINGLE = 3'b001, OP_CONT = 3'b010,
      OP_CAL_ADC_ZS = 3'b011, OP_CAL_CH_ZS = 3'b100, OP_CAL_CH_FS = 3'b101
   } op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_SYNC_WAIT = 3'b001, ST_SETTLE1 = 3'b010,
      ST_SAMPLE1 = 3'b011, ST_SETTLE2 = 3'b100, ST_SAMPLE2 = 3'b101,
      ST_SCALE = 3'b110
   } state_t;
endpackage

// ===== conv_sequencer.sv
// conversion sequencer and result post-processing for an eight-channel converter
// assumes synchronous inputs; filter_data holds the filter output at sample end
//
// Behaviour
// - chopped result is the average of normal and reversed polarity conversions
// - each cycle starts with a 44-cycle settling phase before sampling
// - chopping adds a 42-cycle settling phase then sampling with swapped inputs
// - 163-cycle scaling phase averages, calibrates and writes the data register
// - without chopping: one settle, one sample, one 163-cycle scale
// - sampling length comes from the channel's filter word
// - ready output high during scaling; low with flag set on data update
// - continuous mode moves on to the next enabled channel automatically
// - conversion time and chopping held per channel, used when converted
// - modulator runs at half the master clock
// - clamp forces out-of-range data to all zeros or all ones
// - bipolar: zero codes mid-scale, wraps past full scale with overrange
// - unipolar: negative gives zero with sign and overrange, overflow wraps
// - low reference during a conversion sets the missing-reference flag
// - sync hold with sync low keeps operations waiting for sync rising
// - unipolar two-stage scaling divided by 200000h each stage
// - bipolar first stage divided by 400000h and offset by 800000h
// - channel zero value is sign bit plus 22-bit magnitude
// - calibration started by mode write; ends updating cal, all flags, idle
// - calibration lasts as long as a conversion on the selected channel
// - zero self-calibration shorts the inputs to the channel negative input
// - reading a channel's data register clears its ready flag
//
// The placing of the registers and the plain strobed port were decided locally.
module conv_sequencer
   import seq_pkg::*;
#(
   parameter int SAMPLE_UNIT = SAMPLE_UNIT_RST
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [23:0] filter_data,
   input wire logic sync_in,
   input wire logic ref_low,
   output logic ready_n,
   output logic mod_clk_en,
   output logic [2:0] mux_channel,
   output logic inputs_swapped,
   output logic inputs_shorted,
   output logic sampling
);
   // ----------------------------------------
   // register storage
   // ----------------------------------------
   op_t op_q;
   state_t state_q;
   logic [2:0] ch_q;
   logic clamp_q;
   logic sync_hold_q;
   logic [23:0] adc_zs_q;
   logic [23:0] adc_fs_q;
   logic [10:0] cfg_q [8];
   logic [23:0] data_q [8];
   logic [5:0] stat_q [8];
   logic [23:0] ch_zs_q [8];
   logic [23:0] ch_fs_q [8];
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [15:0] cnt_q;
   logic [23:0] raw_a_q;
   logic [23:0] raw_b_q;
   logic refmiss_q;
   logic [31:0] rdata_q;
   logic ready_n_q;
   logic mod_clk_en_q;
   logic swapped_q;
   logic shorted_q;
   logic sampling_q;

   logic mode_wr;
   logic fin;
   logic cal_op;
   logic chop;
   logic bip;
   logic [15:0] samp_len;
   logic [2:0] next_ch;
   logic next_found;
   logic [2:0] rg;
   logic [2:0] ri;

   assign rg = addr[7:5];
   assign ri = addr[4:2];
   assign mode_wr = wr && addr == ADDR_MODE;
   assign fin = state_q == ST_SCALE && cnt_q == 16'h0000;
   assign cal_op = op_q == OP_CAL_ADC_ZS || op_q == OP_CAL_CH_ZS || op_q == OP_CAL_CH_FS;
   assign chop = cfg_q[ch_q][CFG_CHOP_BIT];
   assign bip = cfg_q[ch_q][CFG_BIP_BIT];
   assign samp_len = (cfg_q[ch_q][7:0] == 8'h00) ? 16'(SAMPLE_UNIT) :
                     16'(int'(cfg_q[ch_q][7:0]) * SAMPLE_UNIT);

   // ----------------------------------------
   // next enabled channel search
   // ----------------------------------------
   always_comb
   begin
      next_ch = ch_q;
      next_found = 1'b0;
      for (int k = 1; k <= 8; k++)
      begin
         if (!next_found && cfg_q[3'(ch_q + 3'(k))][CFG_EN_BIT])
         begin
            next_ch = 3'(ch_q + 3'(k));
            next_found = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // result scaling
   // ----------------------------------------
   logic signed [63:0] raw_s;
   logic signed [63:0] prod1;
   logic signed [63:0] stage1;
   logic signed [63:0] chzs_s;
   logic signed [63:0] offs;
   logic signed [63:0] stage2;
   logic signed [63:0] span;
   logic signed [63:0] fs_cal;
   logic signed [63:0] zs_cal;
   logic [23:0] res_data;
   logic res_sign;
   logic res_ovr;

   always_comb
   begin
      if (chop)
         raw_s = (($signed({40'h0, raw_a_q}) - $signed({40'h0, raw_b_q})) >>> 1) + MID_CODE;
      else
         raw_s = $signed({40'h0, raw_a_q});
      prod1 = (raw_s - $signed({40'h0, adc_zs_q})) * $signed({40'h0, adc_fs_q});
      if (bip)
         stage1 = (prod1 >>> BIP_SHIFT) + MID_CODE;
      else
         stage1 = prod1 >>> UNI_SHIFT;
      chzs_s = $signed({42'h0, ch_zs_q[ch_q][21:0]});
      if (ch_zs_q[ch_q][CHZS_SIGN_BIT])
         chzs_s = -chzs_s;
      offs = stage1 - chzs_s;
      stage2 = (offs * $signed({40'h0, ch_fs_q[ch_q]})) >>> UNI_SHIFT;
      span = bip ? offs - MID_CODE : offs;
      if (span > 64'sh0)
         fs_cal = (UNITY_GAIN * (bip ? FULL_CODE - MID_CODE : FULL_CODE)) / span;
      else
         fs_cal = UNITY_GAIN;
      zs_cal = bip ? stage1 - MID_CODE : stage1;
      res_data = stage2[23:0];
      res_sign = bip ? stage2 < MID_CODE : stage2 < 64'sh0;
      res_ovr = stage2 > FULL_CODE || stage2 < 64'sh0;
      if (!bip && stage2 < 64'sh0)
         res_data = 24'h000000;
      if (clamp_q && stage2 > FULL_CODE)
         res_data = 24'hffffff;
      else if (clamp_q && stage2 < 64'sh0)
         res_data = 24'h000000;
   end

   // ----------------------------------------
   // operation control
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_q <= OP_IDLE;
         ch_q <= 3'h0;
         clamp_q <= 1'b0;
      end
      else if (mode_wr)
      begin
         op_q <= op_t'(wdata[MODE_OP_LSB +: 3]);
         ch_q <= wdata[MODE_CH_LSB +: 3];
         clamp_q <= wdata[MODE_CLAMP_BIT];
      end
      else if (fin)
      begin
         if (op_q == OP_CONT && next_found)
            ch_q <= next_ch;
         else
            op_q <= OP_IDLE;
      end
   end

   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 16'h0000;
      end
      else if (mode_wr)
      begin
         state_q <= (wdata[MODE_OP_LSB +: 3] == OP_IDLE) ? ST_IDLE : ST_SYNC_WAIT;
         cnt_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               cnt_q <= 16'h0000;
            end
            ST_SYNC_WAIT:
            begin
               if (!(sync_hold_q && !sync_in))
               begin
                  state_q <= ST_SETTLE1;
                  cnt_q <= 16'(SETTLE1_CYC - 1);
               end
            end
            ST_SETTLE1:
            begin
               if (cnt_q == 16'h0000)
               begin
                  state_q <= ST_SAMPLE1;
                  cnt_q <= samp_len - 16'h0001;
               end
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            ST_SAMPLE1:
            begin
               if (cnt_q == 16'h0000 && chop)
               begin
                  state_q <= ST_SETTLE2;
                  cnt_q <= 16'(SETTLE2_CYC - 1);
               end
               else if (cnt_q == 16'h0000)
               begin
                  state_q <= ST_SCALE;
                  cnt_q <= 16'(SCALE_CYC - 1);
               end
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            ST_SETTLE2:
            begin
               if (cnt_q == 16'h0000)
               begin
                  state_q <= ST_SAMPLE2;
                  cnt_q <= samp_len - 16'h0001;
               end
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            ST_SAMPLE2:
            begin
               if (cnt_q == 16'h0000)
               begin
                  state_q <= ST_SCALE;
                  cnt_q <= 16'(SCALE_CYC - 1);
               end
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            ST_SCALE:
            begin
               if (cnt_q == 16'h0000)
                  state_q <= (op_q == OP_CONT && next_found) ? ST_SYNC_WAIT : ST_IDLE;
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            default:
            begin
               state_q <= ST_IDLE;
               cnt_q <= 16'h0000;
            end
         endcase
      end
   end

   // ----------------------------------------
   // filter capture and reference watch
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_a_q <= 24'h000000;
         raw_b_q <= 24'h000000;
      end
      else if (cnt_q == 16'h0000 && state_q == ST_SAMPLE1)
         raw_a_q <= filter_data;
      else if (cnt_q == 16'h0000 && state_q == ST_SAMPLE2)
         raw_b_q <= filter_data;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         refmiss_q <= 1'b0;
      else if (state_q == ST_SYNC_WAIT || state_q == ST_IDLE)
         refmiss_q <= 1'b0;
      else if (ref_low)
         refmiss_q <= 1'b1;
   end

   // ----------------------------------------
   // analog front-end controls
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mod_clk_en_q <= 1'b0;
         swapped_q <= 1'b0;
         shorted_q <= 1'b0;
         sampling_q <= 1'b0;
      end
      else
      begin
         sampling_q <= state_q == ST_SAMPLE1 || state_q == ST_SAMPLE2;
         mod_clk_en_q <= (state_q == ST_SAMPLE1 || state_q == ST_SAMPLE2) && !mod_clk_en_q;
         swapped_q <= state_q == ST_SETTLE2 || state_q == ST_SAMPLE2;
         shorted_q <= op_q == OP_CAL_ADC_ZS && state_q != ST_IDLE;
      end
   end

   // ----------------------------------------
   // software settings and calibration values
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_hold_q <= 1'b0;
         adc_zs_q <= ADC_ZS_RST;
         adc_fs_q <= ADC_FS_RST;
         for (int k = 0; k < 8; k++)
         begin
            cfg_q[k] <= CFG_RST;
            ch_zs_q[k] <= CH_ZS_RST;
            ch_fs_q[k] <= CH_FS_RST;
         end
      end
      else if (fin && op_q == OP_CAL_ADC_ZS)
         adc_zs_q <= raw_s[23:0];
      else if (fin && op_q == OP_CAL_CH_ZS)
         ch_zs_q[ch_q] <= {1'b0, zs_cal < 64'sh0,
                           zs_cal < 64'sh0 ? 22'(-zs_cal) : zs_cal[21:0]};
      else if (fin && op_q == OP_CAL_CH_FS)
         ch_fs_q[ch_q] <= fs_cal[23:0];
      else if (wr)
      begin
         if (addr == ADDR_IO)
            sync_hold_q <= wdata[IO_SYNC_BIT];
         if (addr == ADDR_ADC_ZS)
            adc_zs_q <= wdata[23:0];
         if (addr == ADDR_ADC_FS)
            adc_fs_q <= wdata[23:0];
         if (rg == REG_CFG)
            cfg_q[ri] <= wdata[10:0];
         if (rg == REG_CH_ZS)
            ch_zs_q[ri] <= wdata[23:0];
         if (rg == REG_CH_FS)
            ch_fs_q[ri] <= wdata[23:0];
      end
   end

   // ----------------------------------------
   // result storage
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < 8; k++)
         begin
            data_q[k] <= 24'h000000;
            stat_q[k] <= 6'h00;
         end
      end
      else if (fin && !cal_op)
      begin
         data_q[ch_q] <= res_data;
         stat_q[ch_q] <= {ch_q, refmiss_q || ref_low, res_sign, res_ovr};
      end
   end

   // ----------------------------------------
   // ready flags, one per channel
   // ----------------------------------------
   for (genvar g = 0; g < 8; g++)
   begin : g_flag
      logic set_f;
      logic clr_f;
      assign set_f = fin && (cal_op || ch_q == 3'(g));
      assign clr_f = mode_wr || (rd && rg == REG_DATA && ri == 3'(g));
      assign flags_d[g] = set_f ? 1'b1 : (clr_f ? 1'b0 : flags_q[g]);
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
         if (!rst_n)
            flags_q[g] <= 1'b0;
         else
            flags_q[g] <= flags_d[g];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ready_n_q <= 1'b1;
      else if (mode_wr || (state_q == ST_SCALE && !fin))
         ready_n_q <= 1'b1;
      else
         ready_n_q <= ~|flags_d;
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 32'h00000000;
      else if (rd)
      begin
         case (rg)
            REG_GLOBAL:
            begin
               case (addr)
                  ADDR_MODE: rdata_q <= {25'h0, clamp_q, ch_q, op_q};
                  ADDR_IO: rdata_q <= {31'h0, sync_hold_q};
                  ADDR_FLAGS: rdata_q <= {24'h0, flags_q};
                  ADDR_ADC_ZS: rdata_q <= {8'h0, adc_zs_q};
                  ADDR_ADC_FS: rdata_q <= {8'h0, adc_fs_q};
                  default: rdata_q <= 32'h00000000;
               endcase
            end
            REG_CFG: rdata_q <= {21'h0, cfg_q[ri]};
            REG_DATA: rdata_q <= {8'h0, data_q[ri]};
            REG_STAT: rdata_q <= {26'h0, stat_q[ri]};
            REG_CH_ZS: rdata_q <= {8'h0, ch_zs_q[ri]};
            REG_CH_FS: rdata_q <= {8'h0, ch_fs_q[ri]};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   assign rdata = rdata_q;
   assign ready_n = ready_n_q;
   assign mod_clk_en = mod_clk_en_q;
   assign mux_channel = ch_q;
   assign inputs_swapped = swapped_q;
   assign inputs_shorted = shorted_q;
   assign sampling = sampling_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [15:0] dwell_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         dwell_q <= 16'h0000;
      else if (mode_wr || fin || cnt_q == 16'h0000)
         dwell_q <= 16'h0000;
      else
         dwell_q <= dwell_q + 16'h0001;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_settle_first: assert property (
      ($past(state_q) == ST_SETTLE1 && state_q == ST_SAMPLE1 && !$past(mode_wr))
      |-> $past(dwell_q) == 16'(SETTLE1_CYC - 1))
      else $error("first settling length wrong");
   a_settle_second: assert property (
      ($past(state_q) == ST_SETTLE2 && state_q == ST_SAMPLE2 && !$past(mode_wr))
      |-> $past(dwell_q) == 16'(SETTLE2_CYC - 1))
      else $error("second settling length wrong");
   a_scale_len: assert property (
      ($past(state_q) == ST_SCALE && state_q != ST_SCALE && !$past(mode_wr))
      |-> $past(dwell_q) == 16'(SCALE_CYC - 1))
      else $error("scaling length wrong");
   a_sample_len: assert property (
      ($past(state_q) == ST_SAMPLE1 && state_q != ST_SAMPLE1 && !$past(mode_wr))
      |-> $past(dwell_q) == $past(samp_len) - 16'h0001)
      else $error("sampling length not from filter word");
   a_nochop_path: assert property (
      (state_q == ST_SAMPLE1 && cnt_q == 16'h0000 && !chop && !mode_wr)
      |=> state_q == ST_SCALE)
      else $error("unchopped cycle did not go to scaling");
   a_ready_scale: assert property (
      (state_q == ST_SCALE && $past(state_q) == ST_SCALE) |-> ready_n_q)
      else $error("ready output low during scaling");
   a_ready_update: assert property (
      (fin && !mode_wr) |=> !ready_n_q && flags_q[$past(ch_q)])
      else $error("ready not signalled after update");
   a_mod_half: assert property (
      mod_clk_en_q |=> !mod_clk_en_q)
      else $error("modulator enable faster than half rate");
   a_sync_hold: assert property (
      (state_q == ST_SYNC_WAIT && sync_hold_q && !sync_in && !mode_wr)
      |=> state_q == ST_SYNC_WAIT)
      else $error("operation began while sync held low");
   a_cont_next: assert property (
      (fin && op_q == OP_CONT && next_found && !mode_wr)
      |=> state_q == ST_SYNC_WAIT && ch_q == $past(next_ch))
      else $error("continuous mode did not step channel");
   a_cal_done: assert property (
      (fin && cal_op && !mode_wr) |=> flags_q == 8'hff && op_q == OP_IDLE)
      else $error("calibration end not signalled");
   a_read_clear: assert property (
      (rd && rg == REG_DATA && !fin && !mode_wr) |=> !flags_q[$past(ri)])
      else $error("data read did not clear ready flag");

   c_chop_cycle: cover property (state_q == ST_SAMPLE2 ##1 state_q == ST_SCALE);
   c_cont_step: cover property (fin && op_q == OP_CONT && next_found);
   c_cal_end: cover property (fin && cal_op);
   c_sync_wait: cover property (state_q == ST_SYNC_WAIT [*3]);
endmodule

// ===== filter_model.sv
// stand-in for the converter front end and digital filter
// assumes filter_data is taken at the end of each sampling phase
module filter_model
(
   input wire logic sampling,
   input wire logic inputs_swapped,
   input wire logic [23:0] pos_code,
   input wire logic [23:0] neg_code,
   output logic [23:0] filter_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // outside sampling the output is garbage so a stale value is never taken
   always_comb
      filter_data = !sampling ? ~pos_code : (inputs_swapped ? neg_code : pos_code);
endmodule

// ===== testbench.sv
// self-checking bench for the conversion sequencer
// assumes the filter model as front end and SAMPLE_UNIT of 1
module testbench
   import seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_n = 0, wr = 0, rd = 0, sync_in = 0, ref_low = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [23:0] filter_data, pos_code = 24'h0, neg_code = 24'h0;
   logic ready_n, mod_clk_en, inputs_swapped, inputs_shorted, sampling;
   logic [2:0] mux_channel;
   int err_count = 0, checks = 0, samp_n = 0, swap_n = 0, mclk_n = 0, short_n = 0;
   conv_sequencer #(.SAMPLE_UNIT(1)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .filter_data(filter_data),
      .sync_in(sync_in), .ref_low(ref_low), .ready_n(ready_n), .mod_clk_en(mod_clk_en),
      .mux_channel(mux_channel), .inputs_swapped(inputs_swapped),
      .inputs_shorted(inputs_shorted), .sampling(sampling));
   filter_model fm (.sampling(sampling), .inputs_swapped(inputs_swapped),
      .pos_code(pos_code), .neg_code(neg_code), .filter_data(filter_data));
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      samp_n += int'(sampling === 1'b1);
      swap_n += int'(inputs_swapped === 1'b1);
      mclk_n += int'(mod_clk_en === 1'b1);
      short_n += int'(inputs_shorted === 1'b1);
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic clr();
      #1;
      samp_n = 0;
      swap_n = 0;
      mclk_n = 0;
      short_n = 0;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      while (ready_n !== 1'b0 && n < 4000)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (n == 4000)
      begin
         err_count++;
         summarize();
      end
   endtask
   // one operation on a channel: timing counts, flags, status and data
   task automatic run(input logic [7:0] ch, input logic [31:0] cfg, input logic [31:0] mode,
      input logic [31:0] dat, input logic [31:0] st, input bit hold);
      wr_reg(8'h20 + {ch[5:0], 2'b00}, cfg);
      clr();
      wr_reg(8'h00, mode);
      @(posedge sys_clk);
      #1 chk(ready_n, 32'h1);
      if (hold)
      begin
         repeat (100) @(posedge sys_clk);
         chk(samp_n, 32'h0);
         sync_in <= 1'b1;
      end
      wait_rdy();
      chk(mux_channel, ch);
      chk(samp_n, cfg[8] ? 32'd16 : 32'd8);
      chk(swap_n, cfg[8] ? 32'd50 : 32'd0);
      chk(mclk_n, cfg[8] ? 32'd8 : 32'd4);
      rd_reg(8'h08);
      chk(v, 32'h1 << ch);
      rd_reg(8'h60 + {ch[5:0], 2'b00});
      chk(v, st);
      rd_reg(8'h40 + {ch[5:0], 2'b00});
      chk(v, dat);
      rd_reg(8'h08);
      chk(v, 32'h0);
      $display("test channel %0d done", ch);
   endtask
   initial
   begin
      int n;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_reg(8'h20);
      chk(v, 32'h208);
      rd_reg(8'h10);
      chk(v, 32'h200000);
      rd_reg(8'hfc);
      chk(v, 32'h0);
      $display("test reset done");
      pos_code <= 24'h400000;
      run(0, 32'h208, 32'h01, 32'h400000, 32'h00, 0);
      pos_code <= 24'ha00000;
      neg_code <= 24'h600000;
      run(1, 32'h308, 32'h09, 32'ha00000, 32'h08, 0);
      pos_code <= 24'h800000;
      run(2, 32'h608, 32'h11, 32'hc00000, 32'h10, 0);
      pos_code <= 24'h900000;
      wr_reg(8'hac, 32'h400000);
      run(3, 32'h208, 32'h19, 32'h200000, 32'h19, 0);
      run(3, 32'h208, 32'h59, 32'hffffff, 32'h19, 0);
      wr_reg(8'h0c, 32'h100000);
      pos_code <= 24'h080000;
      run(4, 32'h208, 32'h21, 32'h0, 32'h23, 0);
      wr_reg(8'h0c, 32'h0);
      pos_code <= 24'h400000;
      ref_low <= 1'b1;
      run(5, 32'h208, 32'h29, 32'h400000, 32'h2c, 0);
      ref_low <= 1'b0;
      wr_reg(8'h04, 32'h1);
      run(6, 32'h208, 32'h31, 32'h400000, 32'h30, 1);
      for (int c = 2; c < 8; c++)
         wr_reg(8'h20 + 8'(c * 4), 32'h008);
      wr_reg(8'h00, 32'h02);
      n = 0;
      v = 0;
      while (v !== 32'h3 && n < 1000)
      begin
         rd_reg(8'h08);
         n++;
      end
      chk(v, 32'h3);
      $display("test continuous done");
      wr_reg(8'h00, 32'h0);
      clr();
      wr_reg(8'h00, 32'h03);
      wait_rdy();
      chk(samp_n, 32'd8);
      chk(32'(short_n > 0), 32'h1);
      rd_reg(8'h08);
      chk(v, 32'hff);
      rd_reg(8'h00);
      chk(v[2:0], 32'h0);
      // channel zero then full calibration on channel 0, converter zero now 400000
      pos_code <= 24'h500000;
      wr_reg(8'h00, 32'h04);
      clr();
      wait_rdy();
      rd_reg(8'h80);
      chk(v, 32'h100000);
      pos_code <= 24'h900000;
      wr_reg(8'h00, 32'h05);
      clr();
      wait_rdy();
      rd_reg(8'ha0);
      chk(v, 32'h7fffff);
      rd_reg(8'h08);
      chk(v, 32'hff);
      $display("test calibration done");
      summarize();
   end
endmodule
